// ===== shared/rdt_pkg.sv
`default_nettype none
package rdt_pkg;
  // register map
  localparam logic [7:0]  RDT_TRIM_ADDR    = 8'h08;
  localparam logic [7:0]  RDT_TRIM_RESET   = 8'h00;
  localparam int          RDT_SIGN_BIT     = 7;
  localparam logic [6:0]  RDT_MAG_OFF      = 7'h00;
  // timebase prescaler
  localparam logic [15:0] RDT_PRE_WRAP     = 16'h8000;
  localparam logic [5:0]  RDT_LAST_SEC     = 6'h3b;
  localparam int          RDT_COARSE_BIT   = 8;
  // square wave taps of the prescaler
  localparam int          RDT_TAP_1HZ      = 14;
  localparam int          RDT_TAP_4K       = 2;
  localparam int          RDT_TAP_8K       = 1;
  localparam int          RDT_TAP_64HZ     = 8;
  localparam logic [1:0]  RDT_FS_1HZ       = 2'h0;
  localparam logic [1:0]  RDT_FS_4K        = 2'h1;
  localparam logic [1:0]  RDT_FS_8K        = 2'h2;
  localparam logic [1:0]  RDT_FS_32K       = 2'h3;
endpackage : rdt_pkg
`default_nettype wire

// ===== rtl/rdt_sync2.sv
`default_nettype none
module rdt_sync2
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // asynchronous levels in, synchronised levels out
  input  wire logic [1:0] async_i,
  output logic      [1:0] sync_o
);

  typedef struct packed
  {
    logic [1:0] meta;
    logic [1:0] stable;
  } rdt_sync_t;

  rdt_sync_t q;
  rdt_sync_t d;

  // first stage feeds only the second
  always_comb
  begin
    d        = q;
    d.meta   = async_i;
    d.stable = q.meta;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign sync_o = q.stable;

endmodule // rdt_sync2
`default_nettype wire

// ===== rtl/rdt_trim.sv
`default_nettype none
module rdt_trim
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // register port from the serial interface
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // timebase and supply state pins
  input  wire logic       osc_clk_i,
  input  wire logic       on_backup_i,
  // control bits from the control register
  input  wire logic       coarse_trim_enable_i,
  input  wire logic       square_wave_enable_i,
  input  wire logic [1:0] output_frequency_select_i,
  // timekeeping and pin outputs
  output logic            sec_tick_o,
  output logic            sqw_o
);

  typedef struct packed
  {
    logic [7:0]  trim;
    logic        osc_prev;
    logic [14:0] pre;
    logic [5:0]  secs;
    logic [7:0]  corr_left;
    logic        corr_add;
    logic        sec_tick;
    logic        sqw;
    logic [7:0]  rdata;
  } rdt_state_t;

  localparam rdt_state_t RST_STATE =
    '{trim: rdt_pkg::RDT_TRIM_RESET, default: '0};

  rdt_state_t  q;
  rdt_state_t  d;
  logic [1:0]  sync_lv;
  logic        osc_s;
  logic        bk_s;
  logic        osc_rise;
  logic [6:0]  mag;
  logic        hold;
  logic [15:0] inc;
  logic [15:0] sum;
  logic        wrap;
  logic        trig_min;
  logic        trig_crs;
  logic        trig;

  rdt_sync2 u_sync
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({on_backup_i, osc_clk_i}),
    .sync_o    (sync_lv)
  );

  assign osc_s = sync_lv[0];
  assign bk_s  = sync_lv[1];

  always_comb
  begin
    d          = q;
    d.sec_tick = 1'b0;
    d.osc_prev = osc_s;
    osc_rise   = osc_s & ~q.osc_prev;
    mag        = q.trim[6:0];
    // removal swallows ticks, insertion counts two per tick
    hold       = (q.corr_left != 8'h00) && !q.corr_add;
    if (hold)
      inc = 16'h0000;
    else if (q.corr_left != 8'h00)
      inc = 16'h0002;
    else
      inc = 16'h0001;
    sum  = {1'b0, q.pre} + inc;
    wrap = sum >= rdt_pkg::RDT_PRE_WRAP;
    trig_min = osc_rise && wrap && !coarse_trim_enable_i
               && (q.secs == rdt_pkg::RDT_LAST_SEC);
    trig_crs = osc_rise && coarse_trim_enable_i
               && (sum[15:rdt_pkg::RDT_COARSE_BIT]
                   != {1'b0, q.pre[14:rdt_pkg::RDT_COARSE_BIT]});
    // backup supply deliberately not a term here
    trig = (trig_min || trig_crs) && (mag != rdt_pkg::RDT_MAG_OFF);
    if (osc_rise)
    begin
      d.pre = wrap ? 15'(sum - rdt_pkg::RDT_PRE_WRAP) : sum[14:0];
      if (q.corr_left != 8'h00)
        d.corr_left = q.corr_left - 8'h01;
      if (wrap)
      begin
        d.sec_tick = 1'b1;
        d.secs = (q.secs == rdt_pkg::RDT_LAST_SEC) ? 6'h00
                                                   : q.secs + 6'h01;
      end
    end
    // a new interval reloads even if the last one ran long
    if (trig)
    begin
      d.corr_left = {mag, 1'b0};
      d.corr_add  = q.trim[rdt_pkg::RDT_SIGN_BIT];
    end
    // no enable bit: the next interval picks up the value
    if (reg_wr_i && (reg_addr_i == rdt_pkg::RDT_TRIM_ADDR))
      d.trim = reg_wdata_i;
    d.rdata = (reg_addr_i == rdt_pkg::RDT_TRIM_ADDR) ? q.trim : 8'h00;
    // square wave is off on backup supply
    if (bk_s || !square_wave_enable_i)
      d.sqw = 1'b0;
    else if (coarse_trim_enable_i)
      d.sqw = q.pre[rdt_pkg::RDT_TAP_64HZ];
    else
    begin
      unique case (output_frequency_select_i)
        rdt_pkg::RDT_FS_1HZ: d.sqw = q.pre[rdt_pkg::RDT_TAP_1HZ];
        rdt_pkg::RDT_FS_4K:  d.sqw = q.pre[rdt_pkg::RDT_TAP_4K];
        rdt_pkg::RDT_FS_8K:  d.sqw = q.pre[rdt_pkg::RDT_TAP_8K];
        rdt_pkg::RDT_FS_32K: d.sqw = osc_s;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      q <= RST_STATE;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign sec_tick_o  = q.sec_tick;
  assign sqw_o       = q.sqw;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_minute;
    (trig_min && mag != 7'h00) |=> (q.corr_left == {$past(mag), 1'b0});
  endproperty
  a_minute: assert property (p_minute)
    else $error("minute correction not loaded");

  property p_sign;
    trig |=> (q.corr_add == $past(q.trim[7]));
  endproperty
  a_sign: assert property (p_sign)
    else $error("correction direction differs from sign bit");

  property p_insert;
    (osc_rise && q.corr_left != 8'h00 && q.corr_add && !wrap)
      |=> (q.pre == $past(q.pre) + 15'h0002);
  endproperty
  a_insert: assert property (p_insert)
    else $error("inserted cycle not counted");

  property p_zero;
    (mag == 7'h00 && q.corr_left == 8'h00 && !trig) |=> (q.corr_left == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("correction with zero magnitude");

  property p_coarse_only;
    (trig && !coarse_trim_enable_i) |-> (q.secs == 6'h3b && wrap);
  endproperty
  a_coarse_only: assert property (p_coarse_only)
    else $error("normal mode correction off the minute");

  property p_backup;
    (trig_crs && bk_s && mag != 7'h00) |=> (q.corr_left != 8'h00);
  endproperty
  a_backup: assert property (p_backup)
    else $error("trim stopped on backup supply");

  property p_write;
    (reg_wr_i && reg_addr_i == 8'h08) ##1 1'b1 ##1 1'b1
      |-> (reg_rdata_o == $past(reg_wdata_i, 2) || $past(reg_wr_i));
  endproperty
  a_write: assert property (p_write)
    else $error("trim register readback mismatch");

  property p_remove;
    (osc_rise && q.corr_left != 8'h00 && !q.corr_add)
      |=> (q.pre == $past(q.pre) && !sec_tick_o);
  endproperty
  a_remove: assert property (p_remove)
    else $error("removed cycle still advanced the prescaler");

  property p_64hz;
    (coarse_trim_enable_i && square_wave_enable_i && !bk_s)
      |=> (sqw_o == $past(q.pre[8]));
  endproperty
  a_64hz: assert property (p_64hz)
    else $error("coarse square wave not on the 64 Hz tap");

  property p_fast_out;
    (!coarse_trim_enable_i && square_wave_enable_i && !bk_s
     && output_frequency_select_i == 2'h3) |=> (sqw_o == $past(osc_s));
  endproperty
  a_fast_out: assert property (p_fast_out)
    else $error("undivided output not taken from raw timebase");

  c_insert: cover property (trig && q.trim[7]);
  c_remove: cover property (trig && !q.trim[7]);
  c_coarse: cover property (trig_crs && mag != 7'h00);

endmodule // rdt_trim
`default_nettype wire

// ===== verification/rdt_host.sv
`default_nettype none
module rdt_host
(
  // clock
  input  wire logic       sys_clk_i,
  // register port
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  // timebase
  output logic            osc_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    osc_clk_o   = 1'b0;
  end
  // crystal runs free: eight system clocks a period, toggling on falling clock edges
  always #160 osc_clk_o = ~osc_clk_o;
  // write strobe lasts one clock from a falling edge, then the write data is inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk_i);
    reg_addr_o  = a;
    reg_wdata_o = v;
    reg_wr_o    = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~v;
  endtask
  // read data lags the address by one cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    @(negedge sys_clk_i);
    v = reg_rdata_i;
  endtask
  // half the error clocks a minute from two frequencies; no clamp past 127
  function automatic logic [7:0] trim_from(input int ideal,
                                           input int meas);
    int e;
    e = (ideal - meas) * 32768 * 60 / (2 * ideal);
    return {e > 0, 7'(e < 0 ? -e : e)};
  endfunction
endmodule // rdt_host
`default_nettype wire

// ===== verification/rdt_trim_test.sv
`default_nettype none
module rdt_trim_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic [7:0] addr, wdata, rdata, v, tv;
  logic       wr, osc, bkp, crs, square_wave_enable, tick, sqw;
  logic [1:0] fs;
  int         err_total, total_checks, osc_n, n, ticks;

  always #20 sys_clk_i = ~sys_clk_i;
  always @(posedge osc) osc_n++;
  // run is well under one second of timebase: any tick is wrong
  always @(negedge sys_clk_i) if (tick !== 1'b0) ticks++;

  rdt_host u_host
  (
    .sys_clk_i   (sys_clk_i),
    .reg_addr_o  (addr),
    .reg_wr_o    (wr),
    .reg_wdata_o (wdata),
    .reg_rdata_i (rdata),
    .osc_clk_o   (osc)
  );

  rdt_trim DUT
  (
    .sys_clk_i                 (sys_clk_i),
    .rst_i                     (rst_i),
    .reg_addr_i                (addr),
    .reg_wr_i                  (wr),
    .reg_wdata_i               (wdata),
    .reg_rdata_o               (rdata),
    .osc_clk_i                 (osc),
    .on_backup_i               (bkp),
    .coarse_trim_enable_i      (crs),
    .square_wave_enable_i      (square_wave_enable),
    .output_frequency_select_i (fs),
    .sec_tick_o                (tick),
    .sqw_o                     (sqw)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // osc rises over k sqw edges; first edges skipped while trim settles
  task automatic span(input int k, output int cnt);
    int a;
    repeat (3) @(sqw);
    a = osc_n;
    repeat (k) @(sqw);
    cnt = osc_n - a;
  endtask

  // osc rises per full period of the divided outputs
  function automatic logic [15:0] exp_full(input logic [1:0] f);
    case (f)
      2'h0: return 16'h8000;
      2'h1: return 16'h0008;
      2'h2: return 16'h0004;
      default: return 16'h0001;
    endcase
  endfunction

  // coarse half period: insert shortens, remove lengthens, zero is plain
  function automatic logic [15:0] exp_half(input logic [7:0] t);
    if (t[6:0] == 7'h00)
      return 16'h0100;
    return t[7] ? 16'(16'h0100 - 2 * t[6:0]) : 16'(16'h0100 + 2 * t[6:0]);
  endfunction

  initial
  begin
    #3_600_000;
    err_total++;
    conclude();
  end

  initial
  begin
    bkp   = 1'b0;
    crs   = 1'b0;
    square_wave_enable = 1'b0;
    fs    = 2'h0;
    void'($urandom(22));
    repeat (4) @(negedge sys_clk_i);
    rst_i = 1'b0;
    u_host.rd(rdt_pkg::RDT_TRIM_ADDR, v);
    chk(v, rdt_pkg::RDT_TRIM_RESET);
    $display("test reset value done");
    tv = 8'($urandom);
    u_host.wr(rdt_pkg::RDT_TRIM_ADDR, tv);
    u_host.wr(8'h09, ~tv);
    u_host.rd(rdt_pkg::RDT_TRIM_ADDR, v);
    chk(v, tv);
    u_host.rd(8'h09, v);
    chk(v, 8'h00);
    $display("test register access done");
    u_host.wr(rdt_pkg::RDT_TRIM_ADDR, 8'h00);
    fs    = 2'($urandom);
    crs   = 1'b1;
    square_wave_enable = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      case (i)
        0: tv = 8'h00;
        1: tv = 8'h80;
        2: tv = 8'h81;
        3: tv = 8'h01;
        4: tv = u_host.trim_from(32768, 32767);
        default: tv = {1'($urandom), 7'(1 + $urandom % 60)};
      endcase
      u_host.wr(rdt_pkg::RDT_TRIM_ADDR, tv);
      span(1, n);
      chk(16'(n), exp_half(tv));
    end
    $display("test coarse trim done");
    // long enough for a coarse interval to trigger while on backup
    bkp = 1'b1;
    repeat (3200) @(negedge sys_clk_i);
    chk(16'(sqw), 16'h0000);
    bkp = 1'b0;
    u_host.wr(rdt_pkg::RDT_TRIM_ADDR, 8'h00);
    crs = 1'b0;
    // let a pending correction drain before timing the taps
    repeat (1200) @(negedge sys_clk_i);
    for (int k = 1; k < 4; k++)
    begin
      fs = 2'(k);
      span(2, n);
      chk(16'(n), exp_full(fs));
    end
    chk(16'(ticks), 16'h0000);
    $display("test output taps done");
    conclude();
  end
endmodule // rdt_trim_test
`default_nettype wire
